// ==== hw/iss_pkg.sv ====
// shared constants and carrier types for the intermittent sensor sampler
package iss_pkg;

  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned SAMPLE_MS       = 1000;
  localparam int unsigned SETTLE_MS       = 125;
  localparam longint unsigned SAMPLE_CYC  = (longint'(CLK_HZ) * SAMPLE_MS) / 1000;
  localparam longint unsigned SETTLE_CYC  = (longint'(CLK_HZ) * SETTLE_MS) / 1000;
  localparam int unsigned ADC_CHANNEL     = 7;
  localparam logic [15:0] THRESHOLD_RST   = 16'hfd0c;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam int unsigned RESULT_W        = 16;

  typedef enum logic [5:0] {
    ISS_IDLE   = 6'b000001,
    ISS_SLEEP  = 6'b000010,
    ISS_SETTLE = 6'b000100,
    ISS_CONV   = 6'b001000,
    ISS_CHECK  = 6'b010000,
    ISS_WAKE   = 6'b100000
  } iss_state_t;

  typedef struct packed {
    logic amplifier_zero_en;
    logic amp1_en;
    logic sensor_power;
    logic settle_run;
  } iss_ctrl_t;

endpackage

// ==== hw/iss_sampler.sv ====
// intermittent sensor sampling sequencer with result fifo
// Overview of operation
// - sampling timer free-runs in timer mode, underflows every 1000 ms, starting a cycle
// - settling timer raises its interval event 125 ms after start
// - underflow enables amplifiers zero and one together via the event link
// - underflow drives the sensor power pin high
// - right after power-on the settling timer control is written to start counting
// - settling interval event triggers one conversion while the processor sleeps
// - converter: single channel seven, one-shot, hardware-trigger wait start
// - conversion end disables amplifiers zero and one
// - conversion end stores the result into the result buffer
// - conversion-end chain drives the sensor power pin low
// - conversion-end chain stops the settling timer
// - chain feeds result to the adder, then re-arms the clockless convert wait
// - sum beyond ffff raises wake interrupt and leaves the clockless convert state
// - sleep entered only after start switch sampled low; sequence repeats after wake
// - after reset the sensor power pin is low until the first underflow that arrives in sleep
// - amplifiers in high-speed, event-link start and conversion stop, trigger zero
// - adder in addition mode, interrupt enabled, accumulator preloaded with threshold
// - without overflow the sequencer returns to sleep and waits for next underflow
// - chain reloads the accumulator with the threshold so each result stands alone
`timescale 1ns/1ns
`default_nettype none

module iss_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             not_full;
  logic             not_empty;
  logic             do_wr;
  logic             do_rd;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  // flags kept in flops so both handshakes see clean levels
  assign in_ready_o  = not_full;
  assign out_valid_o = not_empty;
  assign out_data_o  = mem[rd_ptr];
  assign do_wr       = ce_i && in_valid_i && in_ready_o;
  assign do_rd       = ce_i && out_ready_i && out_valid_o;

  always_comb begin
    next_count = count;
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      not_full  <= 1'b1;
      not_empty <= 1'b0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      count     <= next_count;
      not_full  <= (next_count != (AW+1)'(DEPTH));
      not_empty <= (next_count != '0);
    end
  end
endmodule // iss_fifo

module iss_sampler
  import iss_pkg::*;
#(
  parameter longint unsigned SAMPLE_COUNT = SAMPLE_CYC,
  parameter longint unsigned SETTLE_COUNT = SETTLE_CYC,
  parameter int unsigned     DEPTH        = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                ce_i,
  // processor handshake
  input  wire logic                start_switch_input_i,
  output logic                     sleep_o,
  output logic                     wake_irq_o,
  // sensor and analog front end
  output logic                     sensor_power_pin_o,
  output logic                     amplifier_zero_en_o,
  output logic                     amplifier_one_en_o,
  output logic [3:0]               adc_channel_o,
  output logic                     adc_trigger_o,
  input  wire logic                adc_done_i,
  input  wire logic [RESULT_W-1:0] adc_result_i,
  // result buffer drain
  output logic                     result_valid_o,
  input  wire logic                result_ready_i,
  output logic [RESULT_W-1:0]      result_data_o,
  output logic                     overflow_sum_valid_o
);
  localparam int unsigned TW = 32;

  iss_state_t           state;
  iss_ctrl_t            ctrl;
  logic [TW-1:0]        sample_cnt;
  logic [TW-1:0]        settle_cnt;
  logic                 underflow;
  logic                 settle_evt;
  logic                 clockless_convert_state_arm;
  logic [RESULT_W-1:0]  accum;
  logic [RESULT_W:0]    sum;
  logic [RESULT_W-1:0]  pend_result;
  logic                 push_valid;
  logic                 push_ready;
  logic                 fifo_valid;
  logic [RESULT_W-1:0]  fifo_data;

  if (SAMPLE_COUNT < 4 || SAMPLE_COUNT >= 64'(1) << TW) begin : g_bad_sample
    $error("bad sample count");
  end
  if (SETTLE_COUNT < 1 || SETTLE_COUNT >= SAMPLE_COUNT) begin : g_bad_settle
    $error("bad settle count");
  end

  // sampling timer: free runs in timer mode, never stalls with the chain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sample_cnt <= '0;
      underflow  <= 1'b0;
    end else if (ce_i) begin
      underflow <= 1'b0;
      if (sample_cnt == TW'(SAMPLE_COUNT - 1)) begin
        sample_cnt <= '0;
        underflow  <= 1'b1;
      end else begin
        sample_cnt <= sample_cnt + 1'b1;
      end
    end
  end

  // settling timer, run bit written by the power-on chain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      settle_cnt <= '0;
      settle_evt <= 1'b0;
    end else if (ce_i) begin
      settle_evt <= 1'b0;
      if (!ctrl.settle_run) begin
        settle_cnt <= '0;
      end else if (settle_cnt == TW'(SETTLE_COUNT - 1)) begin
        settle_cnt <= '0;
        settle_evt <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 1'b1;
      end
    end
  end

  // sequencer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state         <= ISS_IDLE;
      ctrl          <= '0;
      clockless_convert_state_arm    <= 1'b0;
      adc_trigger_o <= 1'b0;
      pend_result   <= '0;
    end else if (ce_i) begin
      adc_trigger_o <= 1'b0;
      case (state)
        ISS_IDLE: begin
          if (!start_switch_input_i) begin
            state      <= ISS_SLEEP;
            clockless_convert_state_arm <= 1'b1;
          end
        end
        ISS_SLEEP: begin
          if (underflow) begin
            ctrl.amplifier_zero_en      <= 1'b1;
            ctrl.amp1_en      <= 1'b1;
            ctrl.sensor_power <= 1'b1;
            state             <= ISS_SETTLE;
          end
        end
        ISS_SETTLE: begin
          ctrl.settle_run <= 1'b1;
          if (settle_evt && clockless_convert_state_arm) begin
            adc_trigger_o <= 1'b1;
            clockless_convert_state_arm    <= 1'b0;
            state         <= ISS_CONV;
          end
        end
        ISS_CONV: begin
          if (adc_done_i) begin
            ctrl.amplifier_zero_en      <= 1'b0;
            ctrl.amp1_en      <= 1'b0;
            ctrl.sensor_power <= 1'b0;
            ctrl.settle_run   <= 1'b0;
            pend_result       <= adc_result_i;
            state             <= ISS_CHECK;
          end
        end
        ISS_CHECK: begin
          // hold here while the buffer is full so no result is dropped
          if (push_ready) begin
            clockless_convert_state_arm <= 1'b1;
            state      <= sum[RESULT_W] ? ISS_WAKE : ISS_SLEEP;
          end
        end
        ISS_WAKE: begin
          if (start_switch_input_i) state <= ISS_IDLE;
        end
        default: state <= ISS_IDLE;
      endcase
    end
  end

  assign sum        = {1'b0, pend_result} + {1'b0, accum};
  assign push_valid = (state == ISS_CHECK);

  // accumulator reloaded with the threshold each time so results stand alone
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      accum      <= THRESHOLD_RST;
      wake_irq_o <= 1'b0;
      overflow_sum_valid_o <= 1'b0;
    end else if (ce_i) begin
      wake_irq_o           <= 1'b0;
      overflow_sum_valid_o <= 1'b0;
      // sum lands for one cycle, then the threshold comes back
      if (overflow_sum_valid_o) begin
        accum <= THRESHOLD_RST;
      end
      if (state == ISS_CHECK && push_ready) begin
        wake_irq_o           <= sum[RESULT_W];
        overflow_sum_valid_o <= 1'b1;
        accum                <= sum[RESULT_W-1:0];
      end
    end
  end

  // registered pin outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sensor_power_pin_o  <= 1'b0;
      amplifier_zero_en_o <= 1'b0;
      amplifier_one_en_o  <= 1'b0;
      sleep_o             <= 1'b0;
      adc_channel_o       <= 4'(ADC_CHANNEL);
    end else if (ce_i) begin
      sensor_power_pin_o  <= ctrl.sensor_power;
      amplifier_zero_en_o <= ctrl.amplifier_zero_en;
      amplifier_one_en_o  <= ctrl.amp1_en;
      sleep_o             <= (state != ISS_IDLE) && (state != ISS_WAKE);
      adc_channel_o       <= 4'(ADC_CHANNEL);
    end
  end

  iss_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (pend_result),
    .out_valid_o (fifo_valid),
    .out_ready_i (result_ready_i),
    .out_data_o  (fifo_data)
  );

  assign result_valid_o = fifo_valid;
  assign result_data_o  = fifo_data;

  // assertions
  sequence s_power_on;
    $rose(sensor_power_pin_o) && amplifier_zero_en_o && amplifier_one_en_o;
  endsequence

  property p_sample_period;
    @(posedge clk_i) disable iff (reset_i)
      ce_i && underflow |-> sample_cnt == '0;
  endproperty
  a_sample_period: assert property (p_sample_period) else $error("underflow off count");

  property p_power_on;
    @(posedge clk_i) disable iff (reset_i)
      state == ISS_SLEEP && underflow && ce_i ##1 ce_i |=> s_power_on;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power on missing");

  property p_trigger_once;
    @(posedge clk_i) disable iff (reset_i)
      adc_trigger_o |-> state == ISS_CONV;
  endproperty
  a_trigger_once: assert property (p_trigger_once) else $error("trigger outside conv");

  property p_power_off;
    @(posedge clk_i) disable iff (reset_i)
      state == ISS_CONV && adc_done_i && ce_i |=> !ctrl.sensor_power && !ctrl.settle_run;
  endproperty
  a_power_off: assert property (p_power_off) else $error("power off missing");

  property p_amps_off;
    @(posedge clk_i) disable iff (reset_i)
      state == ISS_CONV && adc_done_i && ce_i |=> !ctrl.amplifier_zero_en && !ctrl.amp1_en;
  endproperty
  a_amps_off: assert property (p_amps_off) else $error("amplifiers left on");

  property p_add;
    @(posedge clk_i) disable iff (reset_i)
      ce_i && state == ISS_CHECK && push_ready |=> accum == $past(sum[RESULT_W-1:0]);
  endproperty
  a_add: assert property (p_add) else $error("sum not accumulated");

  property p_wake;
    @(posedge clk_i) disable iff (reset_i)
      ce_i && state == ISS_CHECK && push_ready && sum[RESULT_W] |=> wake_irq_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not raised");

  property p_reload;
    @(posedge clk_i) disable iff (reset_i)
      ce_i && overflow_sum_valid_o |=> accum == THRESHOLD_RST;
  endproperty
  a_reload: assert property (p_reload) else $error("accumulator not reloaded");

  property p_no_sleep_early;
    @(posedge clk_i) disable iff (reset_i)
      state == ISS_IDLE && start_switch_input_i && ce_i |=> state == ISS_IDLE;
  endproperty
  a_no_sleep_early: assert property (p_no_sleep_early) else $error("slept early");

  property p_channel;
    @(posedge clk_i) disable iff (reset_i)
      adc_channel_o == 4'(ADC_CHANNEL);
  endproperty
  a_channel: assert property (p_channel) else $error("wrong channel");

endmodule // iss_sampler

`default_nettype wire

// ==== verification/iss_sensor_model.sv ====
// sensor and converter model answering conversion triggers
`timescale 1ns/1ns
`default_nettype none
module iss_sensor_model
  import iss_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // from the sampler
  input  wire logic        adc_trigger_i,
  input  wire logic [3:0]  adc_channel_i,
  input  wire logic        power_i,
  // bench controls
  input  wire logic        slow_i,
  input  wire logic [15:0] value_i,
  // to the sampler
  output logic             adc_done_o,
  output logic [15:0]      adc_result_o
);
  logic [4:0] wait_cnt;
  logic       busy;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy         <= 1'b0;
      wait_cnt     <= 5'h00;
      adc_done_o   <= 1'b0;
      adc_result_o <= 16'h0000;
    end else begin
      adc_done_o <= 1'b0;
      // idle result bus keeps changing so a stale read shows
      if (!busy) adc_result_o <= ~adc_result_o;
      if (adc_trigger_i && !busy) begin
        busy     <= 1'b1;
        wait_cnt <= slow_i ? 5'h0c : 5'h01;
      end else if (busy && wait_cnt != 5'h00) begin
        wait_cnt <= wait_cnt - 5'h01;
      end else if (busy) begin
        busy         <= 1'b0;
        adc_done_o   <= 1'b1;
        adc_result_o <= (adc_channel_i == 4'h7 && power_i) ? value_i : ~value_i;
      end
    end
  end
endmodule // iss_sensor_model
`default_nettype wire

// ==== verification/iss_sampler_tb.sv ====
// self-checking bench for the intermittent sensor sampler
`timescale 1ns/1ns
`default_nettype none
module iss_sampler_tb;
  import iss_pkg::*;
  localparam int SMP = 200;
  localparam int STL = 20;
  logic clk_i, reset_i, ce, start, ready, done, slow, pw, a0, a1, slp, wk, trg, rv, ov;
  logic [15:0] value, result, rdata;
  logic [3:0]  chan;
  logic [15:0] q[$];
  int n_fail, check_count, last_rise, hold;
  int cyc = 0;

  iss_sampler #(.SAMPLE_COUNT(SMP), .SETTLE_COUNT(STL), .DEPTH(16)) iss_sampler_i (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .start_switch_input_i(start),
    .sleep_o(slp), .wake_irq_o(wk), .sensor_power_pin_o(pw), .amplifier_zero_en_o(a0),
    .amplifier_one_en_o(a1), .adc_channel_o(chan), .adc_trigger_o(trg), .adc_done_i(done),
    .adc_result_i(result), .result_valid_o(rv), .result_ready_i(ready),
    .result_data_o(rdata), .overflow_sum_valid_o(ov));

  iss_sensor_model iss_sensor_model_i (.clk_i(clk_i), .reset_i(reset_i), .adc_trigger_i(trg),
    .adc_channel_i(chan), .power_i(pw), .slow_i(slow), .value_i(value),
    .adc_done_o(done), .adc_result_o(result));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // one full sampling cycle; full means the result fifo is expected to hold the check back
  task automatic sample(input logic [15:0] r, input logic sl, input bit per, input bit full);
    int n;
    logic w, o;
    @(posedge clk_i);
    value <= r;
    slow  <= sl;
    #1;
    n = 0;
    while (pw !== 1'b1 && n < 400) begin
      @(posedge clk_i); #1;
      n++;
    end
    chk("power_on", 1, pw);
    chk("amps_on", 2'b11, {a0, a1});
    chk("sleep", 1, slp);
    if (per) chk("period", SMP, cyc - last_rise);
    last_rise = cyc;
    n = 0;
    // clock enable low for hold cycles must stretch the settling wait by as many
    if (hold != 0) begin
      @(posedge clk_i);
      ce <= 1'b0;
      repeat (hold) @(posedge clk_i);
      ce <= 1'b1;
      #1;
      chk("frozen_power", 1, pw);
      n = hold + 1;
    end
    while (trg !== 1'b1 && n < 100) begin
      @(posedge clk_i); #1;
      n++;
    end
    chk("settle", STL + 1 + hold, n);
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk_i); #1;
      n++;
    end
    w = 1'b0;
    o = 1'b0;
    repeat (full ? 10 : 4) begin
      @(posedge clk_i); #1;
      w = w | wk;
      o = o | ov;
    end
    q.push_back(r);
    if (full) begin
      chk("stall", 0, o);
    end else begin
      chk("power_off", 0, pw);
      chk("amps_off", 0, {a0, a1});
      chk("check_done", 1, o);
      chk("wake", ({1'b0, r} + {1'b0, THRESHOLD_RST}) > 17'h0ffff, w);
    end
  endtask

  // release the fifo and compare everything stored, in order
  task automatic drain();
    @(posedge clk_i);
    ready <= 1'b1;
    repeat (60) begin
      #1;
      if (rv === 1'b1) chk("fifo_data", q.pop_front(), rdata);
      @(posedge clk_i);
    end
    #1;
    chk("fifo_empty", 0, {rv, q.size() != 0});
    @(posedge clk_i);
    ready <= 1'b0;
  endtask

  initial begin
    reset_i = 1'b1;
    ce = 1'b1;
    hold = 0;
    start = 1'b1;
    ready = 1'b0;
    slow = 1'b0;
    value = 16'h0000;
    n_fail = 0;
    check_count = 0;
    last_rise = 0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (250) @(posedge clk_i);
    #1;
    chk("idle", 0, {slp, pw, a0, a1});
    chk("channel", ADC_CHANNEL, chan);
    @(posedge clk_i);
    start <= 1'b0;
    sample(16'h0200, 1'b0, 0, 0);
    sample(16'h0200, 1'b1, 1, 0);
    sample(16'h02f3, 1'b0, 1, 0);
    sample(16'h02f4, 1'b1, 0, 0);
    repeat (3) @(posedge clk_i);
    #1;
    chk("awake", 0, slp);
    @(posedge clk_i);
    start <= 1'b1;
    repeat (3) @(posedge clk_i);
    start <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("sleep_again", 1, slp);
    hold = 4;
    for (int i = 0; i < 12; i++) sample(16'h0010 + 16'(i), i[0], 0, 0);
    sample(16'h0123, 1'b0, 0, 1);
    drain();
    finish_test();
  end
endmodule // iss_sampler_tb
`default_nettype wire
